// *** high_port_pullup_latch_logic.v ***
// Purpose: Ports four and five latches, output modes, pullups, pin reads.
// Assumes: The core gives an 8-bit register port; memory interface
//          controls arrive as plain levels for the current cycle.
// Notes:   Read data is registered and valid the cycle after rd_en.
//          Pin outputs follow register state combinationally.
`timescale 1ns/1ns
`include "high_port_consts.vh"

// What this block does
// - Every pin has its weak pullup on after reset.
// - Pullup disable bit set turns all pullups off together.
// - A pin driving low has its own pullup switched off.
// - External move on high ports drives the port four strobe pins, and port five when non-multiplexed, ignoring latch contents.
// - External move read floats no pins here; the data bus sits on another port.
// - Memory activity never changes a pin's open-drain or push-pull mode.
// - Port four latch bits drive pins; one floats in open-drain.
// - Port five latch bits drive pins; one floats in open-drain.
// - Plain port data reads (rmw_read clear) return pin levels, not latch contents.
// - Port four bits 7,6,5 carry write, read and address strobes.
// - Non-multiplexed mode puts address 15:8 on port five.
// - Mode bit one is push-pull, zero open-drain; reset open-drain.
// - Read-modify-write reads return latch contents, not pins.
module high_port_pullup_latch_logic (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Register port
    input  wire [2:0] reg_addr,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    input  wire       rmw_read,
    output reg  [7:0] rd_data_q,
    // Memory interface controls
    input  wire       xmem_high_en,
    input  wire       xmem_active,
    input  wire       xmem_read,
    input  wire       xmem_nonmux,
    input  wire       xmem_wr_strobe_n,
    input  wire       xmem_rd_strobe_n,
    input  wire       xmem_ale,
    input  wire [7:0] xmem_addr_hi,
    // Port four pins
    input  wire [7:0] port4_pin_in,
    output wire [7:0] port4_pin_out,
    output wire [7:0] port4_pin_oe_n,
    output wire [7:0] port4_pullup_en,
    // Port five pins
    input  wire [7:0] port5_pin_in,
    output wire [7:0] port5_pin_out,
    output wire [7:0] port5_pin_oe_n,
    output wire [7:0] port5_pullup_en
);

    // Register state and next values.
    reg  [7:0] port4_output_latch_q;
    reg  [7:0] port4_output_latch_d;
    reg  [7:0] port4_output_mode_q;
    reg  [7:0] port4_output_mode_d;
    reg  [7:0] port5_output_latch_q;
    reg  [7:0] port5_output_latch_d;
    reg  [7:0] port5_output_mode_q;
    reg  [7:0] port5_output_mode_d;
    reg  [7:0] crossbar_config_two_q;
    reg  [7:0] crossbar_config_two_d;
    reg  [7:0] rd_data_d;
    // Pin control.
    wire       global_pullup_disable;
    wire       move_on;
    reg  [7:0] port4_sel;
    reg  [7:0] port4_val;
    wire [7:0] port5_sel;
    wire [7:0] port5_float;

    // True when the write strobe targets the given register index.
    function reg_write_hit;
        input       en;
        input [2:0] addr;
        input [2:0] index;
        begin
            reg_write_hit = en & (addr == index);
        end
    endfunction

    // Selects the port data byte for a read; shared by both ports.
    function [7:0] port_read;
        input       rmw;
        input [7:0] latch;
        input [7:0] pins;
        begin
            port_read = rmw ? latch : pins;
        end
    endfunction

    // A write replaces the whole byte of the register it hits.
    // Writes to an unmapped index fall through and change nothing.
    always @* begin
        port4_output_latch_d  = port4_output_latch_q;
        port4_output_mode_d   = port4_output_mode_q;
        port5_output_latch_d  = port5_output_latch_q;
        port5_output_mode_d   = port5_output_mode_q;
        crossbar_config_two_d = crossbar_config_two_q;
        if (reg_write_hit(wr_en, reg_addr, `REG_PORT4_LATCH)) begin
            port4_output_latch_d = wr_data;
        end
        if (reg_write_hit(wr_en, reg_addr, `REG_PORT4_MODE)) begin
            port4_output_mode_d = wr_data;
        end
        if (reg_write_hit(wr_en, reg_addr, `REG_PORT5_LATCH)) begin
            port5_output_latch_d = wr_data;
        end
        if (reg_write_hit(wr_en, reg_addr, `REG_PORT5_MODE)) begin
            port5_output_mode_d = wr_data;
        end
        if (reg_write_hit(wr_en, reg_addr, `REG_XBAR_TWO)) begin
            crossbar_config_two_d = wr_data;
        end
    end

    // Everything resets synchronously; pins come up released, pulled up.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            port4_output_latch_q  <= `LATCH_RESET;
            port5_output_latch_q  <= `LATCH_RESET;
            port4_output_mode_q   <= `MODE_RESET;
            port5_output_mode_q   <= `MODE_RESET;
            crossbar_config_two_q <= `XBAR_TWO_RESET;
        end else begin
            port4_output_latch_q  <= port4_output_latch_d;
            port5_output_latch_q  <= port5_output_latch_d;
            port4_output_mode_q   <= port4_output_mode_d;
            port5_output_mode_q   <= port5_output_mode_d;
            crossbar_config_two_q <= crossbar_config_two_d;
        end
    end

    // A port index returns the live pin levels unless the core flags the
    // read half of a read-modify-write, which must see the latch instead.
    always @* begin
        case (reg_addr)
            `REG_PORT4_LATCH: rd_data_d = port_read(rmw_read,
                                                    port4_output_latch_q,
                                                    port4_pin_in);
            `REG_PORT4_MODE:  rd_data_d = port4_output_mode_q;
            `REG_PORT5_LATCH: rd_data_d = port_read(rmw_read,
                                                    port5_output_latch_q,
                                                    port5_pin_in);
            `REG_PORT5_MODE:  rd_data_d = port5_output_mode_q;
            `REG_XBAR_TWO:    rd_data_d = crossbar_config_two_q;
            default:          rd_data_d = 8'h00;
        endcase
    end

    // Read data holds between reads, so a late sample by the core still
    // sees the byte taken at its own read edge.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_q <= `RD_DATA_RESET;
        end else if (rd_en) begin
            rd_data_q <= rd_data_d;
        end
    end

    // One crossbar bit cuts every pullup; each driver still cuts its own
    // pullup while its pin is pulled low.
    assign global_pullup_disable =
        crossbar_config_two_q[`XBAR_PULLUP_DIS_BIT];

    // Low-port select is stored but only software obeys it; the
    // interface uses the high ports whenever xmem_high_en is set.
    assign move_on = xmem_high_en & xmem_active;

    // Port four: only the three strobe pins are taken over; the other
    // five keep following their latch bits.
    always @* begin
        port4_sel = 8'h00;
        port4_val = 8'h00;
        port4_sel[`PORT4_WR_STROBE_BIT] = move_on;
        port4_sel[`PORT4_RD_STROBE_BIT] = move_on;
        port4_sel[`PORT4_ADDR_LATCH_BIT] = move_on;
        port4_val[`PORT4_WR_STROBE_BIT] = xmem_wr_strobe_n;
        port4_val[`PORT4_RD_STROBE_BIT] = xmem_rd_strobe_n;
        port4_val[`PORT4_ADDR_LATCH_BIT] = xmem_ale;
    end

    // Port five carries the high address only in non-multiplexed mode;
    // in multiplexed mode its pins stay with the latch.
    assign port5_sel = {8{move_on & xmem_nonmux}};
    // The data bus sits on another port, so a read floats nothing here.
    assign port5_float = {8{xmem_read & 1'b0}};

    // Output mode is kept under override, so an open-drain strobe pin
    // only pulls low and leans on its pullup for the high level.
    port_pin_driver u_port4 (
        .latch      (port4_output_latch_q),
        .push_pull  (port4_output_mode_q),
        .pullup_off (global_pullup_disable),
        .ovr_sel    (port4_sel),
        .ovr_val    (port4_val),
        .ovr_float  (8'h00),
        .pin_out    (port4_pin_out),
        .pin_oe_n   (port4_pin_oe_n),
        .pullup_en  (port4_pullup_en)
    );

    // Port five is an address bus here, so a read never floats it.
    port_pin_driver u_port5 (
        .latch      (port5_output_latch_q),
        .push_pull  (port5_output_mode_q),
        .pullup_off (global_pullup_disable),
        .ovr_sel    (port5_sel),
        .ovr_val    (xmem_addr_hi),
        .ovr_float  (port5_float),
        .pin_out    (port5_pin_out),
        .pin_oe_n   (port5_pin_oe_n),
        .pullup_en  (port5_pullup_en)
    );

endmodule // high_port_pullup_latch_logic

// *** high_port_consts.vh ***
// Purpose: Constants for the high port pullup and output latch block.
// Assumes: One 8-bit register space reached through the special-function
//          register port of the core.
// Notes:   Offsets are index values within the port block.
`ifndef HIGH_PORT_CONSTS_VH
`define HIGH_PORT_CONSTS_VH

`define REG_PORT4_LATCH      3'h0
`define REG_PORT4_MODE       3'h1
`define REG_PORT5_LATCH      3'h2
`define REG_PORT5_MODE       3'h3
`define REG_XBAR_TWO         3'h4

`define LATCH_RESET          8'hFF
`define MODE_RESET           8'h00
`define XBAR_TWO_RESET       8'h00
`define RD_DATA_RESET        8'h00

`define XBAR_PULLUP_DIS_BIT  7
`define XBAR_LOW_SEL_BIT     5

`define PORT4_WR_STROBE_BIT  7
`define PORT4_RD_STROBE_BIT  6
`define PORT4_ADDR_LATCH_BIT 5

`endif

// *** port_pin_driver.v ***
// Purpose: Per-port pin driver: latch, output mode and memory override.
// Assumes: Pin inputs are synchronous to sys_clk.
// Notes:   Output enable is active low, as for all two-way pins here.
`timescale 1ns/1ns

module port_pin_driver (
    // Register state
    input  wire [7:0] latch,
    input  wire [7:0] push_pull,
    input  wire       pullup_off,
    // Memory interface override
    input  wire [7:0] ovr_sel,
    input  wire [7:0] ovr_val,
    input  wire [7:0] ovr_float,
    // Pin
    output wire [7:0] pin_out,
    output wire [7:0] pin_oe_n,
    output wire [7:0] pullup_en
);

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            wire val;
            wire fl;
            assign val = ovr_sel[i] ? ovr_val[i] : latch[i];
            assign fl  = ovr_sel[i] & ovr_float[i];
            assign pin_out[i] = val;
            // Drive when low, or when high in push-pull mode.
            assign pin_oe_n[i] = fl | ~(~val | push_pull[i]);
            assign pullup_en[i] = ~pullup_off
                                  & ~(~fl & ~val);
        end
    endgenerate

endmodule // port_pin_driver

// *** hp_monitor.sv ***
// Purpose: Port-level checks for the high port block.
// Assumes: Sees only the block's ports.
// Notes: Checks are off while in reset.
`timescale 1ns/1ns
module hp_monitor(input wire sys_clk,rst_n,wr_en,rd_en,rmw_read,
    input wire xmem_high_en,xmem_active,xmem_nonmux,xmem_wr_strobe_n,
    input wire xmem_rd_strobe_n,xmem_ale,input wire [2:0] reg_addr,
    input wire [7:0] wr_data,rd_data_q,xmem_addr_hi,port4_pin_in,
    input wire [7:0] port4_pin_out,port4_pin_oe_n,port4_pullup_en,
    input wire [7:0] port5_pin_out,port5_pin_oe_n,port5_pullup_en);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire ov = xmem_high_en & xmem_active;
    a_reset_pullup: assert property ($rose(rst_n) |->
        (port4_pullup_en & port5_pullup_en) == 8'hFF)
        else $error("pullup off");
    a_global_off: assert property (wr_en && reg_addr == 3'h4 &&
        wr_data[7] |=> (port4_pullup_en | port5_pullup_en) == 8'h00)
        else $error("pullup kept");
    a_low_no_pull: assert property ((
        (~port4_pin_oe_n & ~port4_pin_out & port4_pullup_en) |
        (~port5_pin_oe_n & ~port5_pin_out & port5_pullup_en)) == 8'h00)
        else $error("pullup on low pin");
    a_port4_drive: assert property (wr_en && reg_addr == 3'h0 ##1
        !ov |-> ((port4_pin_oe_n | port4_pin_out) & ~$past(wr_data))
        == 8'h00) else $error("port four zero not driven");
    a_port5_drive: assert property (wr_en && reg_addr == 3'h2 ##1
        !ov |-> ((port5_pin_oe_n | port5_pin_out) & ~$past(wr_data))
        == 8'h00) else $error("port five zero not driven");
    a_read_pins: assert property (rd_en && reg_addr == 3'h0 &&
        !rmw_read |=> rd_data_q == $past(port4_pin_in))
        else $error("read not pins");
    a_rmw_latch: assert property (wr_en && reg_addr == 3'h0 ##1
        rd_en && reg_addr == 3'h0 && rmw_read && !wr_en |=>
        rd_data_q == $past(wr_data, 2)) else $error("rmw read not latch");
    a_strobe_drive: assert property (ov |-> ((port4_pin_oe_n[7:5] |
        port4_pin_out[7:5]) & ~{xmem_wr_strobe_n, xmem_rd_strobe_n,
        xmem_ale}) == 3'h0) else $error("strobe low not driven");
    a_addr_high: assert property (ov && xmem_nonmux |->
        ((port5_pin_oe_n | port5_pin_out) & ~xmem_addr_hi) == 8'h00)
        else $error("address bad");
    cover property (ov && xmem_nonmux);
    cover property (rd_en && rmw_read);
    cover property (wr_en && reg_addr == 3'h4 && wr_data[7]);
endmodule // hp_monitor
bind high_port_pullup_latch_logic hp_monitor i_mon(.*);

// *** pin_model.sv ***
// Purpose: Board-side pins of one port.
// Assumes: ext_low pulls only released pins.
// Notes: A pin with nothing on it toggles, so it never reads stable.
`timescale 1ns/1ns
module pin_model(input wire sys_clk, input wire [7:0] pin_out, oe_n,
    input wire [7:0] pullup_en, ext_low, output logic [7:0] level);
    logic t = 1'b0;
    always @(posedge sys_clk) t <= ~t;
    always_comb for (int i = 0; i < 8; i++)
        level[i] = !oe_n[i] ? pin_out[i] : ext_low[i] ? 1'b0 :
                   pullup_en[i] ? 1'b1 : t;
endmodule // pin_model

// *** high_port_pullup_latch_logic_test.sv ***
// Purpose: Self-checking bench for the high port block.
// Assumes: Inputs change on the falling edge.
// Notes: Two pin models stand in for the board.
`timescale 1ns/1ns
`define CHK(a,e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module high_port_pullup_latch_logic_test;
logic sys_clk=0,rst_n=0,wr_en=0,rd_en=0,rmw_read=0,hi_en=0,act=0,rdm=0;
logic nmx=0,wr_n=1,rd_n=1,ale=0;
logic [2:0] reg_addr=0;
logic [7:0] wr_data=0,ahi=0,x4=0,x5=0,q;
wire [7:0] rdq,o4,e4,u4,l4,o5,e5,u5,l5;
int failures=0,comparisons=0,cyc=0;
always #50 sys_clk = ~sys_clk;
high_port_pullup_latch_logic i_dut(.sys_clk(sys_clk),.rst_n(rst_n),
 .reg_addr(reg_addr),.wr_en(wr_en),.wr_data(wr_data),.rd_en(rd_en),
 .rmw_read(rmw_read),.rd_data_q(rdq),.xmem_high_en(hi_en),
 .xmem_active(act),.xmem_read(rdm),.xmem_nonmux(nmx),
 .xmem_wr_strobe_n(wr_n),.xmem_rd_strobe_n(rd_n),.xmem_ale(ale),
 .xmem_addr_hi(ahi),.port4_pin_in(l4),.port4_pin_out(o4),
 .port4_pin_oe_n(e4),.port4_pullup_en(u4),.port5_pin_in(l5),
 .port5_pin_out(o5),.port5_pin_oe_n(e5),.port5_pullup_en(u5));
pin_model m4(.sys_clk(sys_clk),.pin_out(o4),.oe_n(e4),.pullup_en(u4),
 .ext_low(x4),.level(l4));
pin_model m5(.sys_clk(sys_clk),.pin_out(o5),.oe_n(e5),.pullup_en(u5),
 .ext_low(x5),.level(l5));
task tally_and_finish;
 $display("comparisons %0d failures %0d", comparisons, failures);
 if (failures == 0 && comparisons > 0) $display("== PASSED ==");
 else $display("== FAILED ==");
 $finish;
endtask
always @(posedge sys_clk) begin
 cyc++;
 if (cyc == 3000) begin failures++; tally_and_finish; end
end
task wr(input [2:0] a, input [7:0] d);
 @(negedge sys_clk); reg_addr = a; wr_data = d; wr_en = 1;
 @(negedge sys_clk); wr_en = 0;
endtask
task rd(input [2:0] a, input m);
 @(negedge sys_clk); reg_addr = a; rmw_read = m; rd_en = 1;
 @(negedge sys_clk); rd_en = 0; rmw_read = 0; q = rdq;
endtask
task t_reset;
 `CHK({u4,u5},16'hFFFF)
 `CHK({e4,e5},16'hFFFF)
 rd(3'h1,0); `CHK(q,8'h00)
 rd(3'h2,1); `CHK(q,8'hFF)
 rd(3'h0,0); `CHK(q,8'hFF)
 $display("t_reset done");
endtask
task t_port4;
 wr(3'h1,8'h0F); wr(3'h0,8'h5A); x4 = 8'h40;
 @(negedge sys_clk); `CHK(e4,8'h50)
 `CHK(u4,8'h5A)
 rd(3'h0,0); `CHK(q,8'h1A)
 rd(3'h0,1); `CHK(q,8'h5A)
 x4 = 0; $display("t_port4 done");
endtask
task t_port5;
 wr(3'h3,8'hFF); wr(3'h2,8'h00); `CHK({e5,u5,l5},24'h0)
 $display("t_port5 done");
endtask
task t_global;
 // Select bit five is left clear, as software should for high ports.
 wr(3'h4,8'h80); `CHK({u4,u5},16'h0)
 wr(3'h4,8'h00); `CHK(u4,8'h5A)
 $display("t_global done");
endtask
task t_external_memory_interface;
 wr(3'h1,8'h00); @(negedge sys_clk);
 rd_n = 0; ale = 1; ahi = 8'hC3; hi_en = 1; act = 1; rdm = 1; nmx = 1;
 @(negedge sys_clk); `CHK(e4[7:5],3'b101)
 `CHK(l4[7:5],3'b101)
 `CHK({e5,l5},16'h00C3)
 act = 0; @(negedge sys_clk); `CHK(l5,8'h00)
 $display("t_external_memory_interface done");
endtask
// A write followed at once by a read-modify-write read of the same port.
task t_b2b;
 @(negedge sys_clk); reg_addr = 3'h0; wr_data = 8'hA5; wr_en = 1;
 @(negedge sys_clk); wr_en = 0; rmw_read = 1; rd_en = 1;
 @(negedge sys_clk); rd_en = 0; rmw_read = 0; `CHK(rdq,8'hA5)
 `CHK(l4,8'hA5)
 $display("t_b2b done");
endtask
initial begin
 repeat (20) @(negedge sys_clk);
 rst_n = 1;
 t_reset; t_port4; t_port5; t_global; t_external_memory_interface; t_b2b;
 tally_and_finish;
end
endmodule // high_port_pullup_latch_logic_test
